// File: core/fcs_scan_map.svh
/*
  Register map, field positions, reset values and timing counts of the
  flash checksum scanner. Assumes inclusion by its bare name.
*/
`ifndef FCS_SCAN_MAP_SVH
`define FCS_SCAN_MAP_SVH

`define FCS_IDX_CTRL_FIRST 2'h0
`define FCS_IDX_CTRL_SECOND 2'h1
`define FCS_IDX_STATE 2'h2

`define FCS_BIT_ENABLE 0
`define FCS_BIT_FAIL_IRQ_EN 1
`define FCS_BIT_SOFT_RESET 7
`define FCS_BIT_BUSY 0
`define FCS_BIT_PASS 1
`define FCS_SRC_LSB 0
`define FCS_MODE_LSB 4

`define FCS_RST_ENABLE 1'h0
`define FCS_RST_FAIL_IRQ_EN 1'h0
`define FCS_RST_MODE 2'h0
`define FCS_RST_SRC 2'h0
`define FCS_RST_BUSY 1'h0
`define FCS_RST_PASS 1'h1
`define FCS_CLR_PASS 1'h0

`define FCS_MODE_PRIORITY 2'h0
`define FCS_MODE_STARTUP 2'h1
`define FCS_SRC_FLASH 2'h0
`define FCS_SRC_BOOT_AND_APP 2'h1
`define FCS_SRC_BOOT 2'h2

`define FCS_CRC_INIT 16'hFFFF
`define FCS_CRC_POLY 16'h1021
`define FCS_CRC_GOOD 16'h0000

`define FCS_START_DLY_LAST 2'h2
`define FCS_FETCH_DIV_LAST 2'h2
`define FCS_FETCH_ISSUE 2'h0

`endif

// File: core/fcs_scan_pkg.sv
/*
  Types shared by the flash checksum scanner: scan states and the internal
  register write request. Assumes the map header for field positions.
*/
package fcs_scan_pkg;

  typedef enum logic [1:0] {
    FCS_IDLE = 2'h0,
    FCS_DELAY = 2'h1,
    FCS_RUN = 2'h3,
    FCS_CHECK = 2'h2
  } fcs_state_e;

  typedef struct packed {
    logic valid;
    logic from_dbg;
    logic [1:0] idx;
    logic [7:0] data;
  } fcs_wr_s;

endpackage : fcs_scan_pkg

// File: core/fcs_scan_top.sv
/*
  Flash checksum scanner control: Wishbone classic register slave, debugger
  write port, CRC-16 scan over a flash section and the failure interrupt.
  Assumes a synchronous flash that returns data one cycle after a read pulse,
  and section end word indices supplied by configuration inputs.
*/
// Summary of operation
// - Debugger pass clear raises interrupt if interrupt enable is set, then locks
// - Debugger pass write one sets pass
// - Debugger control writes behave like processor writes
// - Soft reset clears registers one cycle later
// - Interrupt enable off: soft reset always accepted
// - Interrupt enable on: soft reset only idle
// - Interrupt enable raises interrupt on mismatch
// - Only system reset clears interrupt enable
// - Interrupt enable set only while idle
// - Raised interrupt blocks first control writes
// - Enable write one starts check, stays one
// - Enable write zero changes nothing
// - Start-up scan leaves enable reading one
// - Second control locked while busy or interrupted
// - Mode zero is priority check stalling processor
// - Start-up scan leaves mode non-zero
// - Section select picks whole, boot+app, boot
// - Start-up scan leaves checked section readable
// - Pass flag resets to one on system reset, soft reset clears it
// - Busy reads one during a check
// - CRC-16-CCITT, MSB first, seed all ones
// - Check begins three cycles after enable
// - One flash word fetched every third cycle
// - Interrupt request sticks until system reset
`timescale 1ns/1ps
`include "fcs_scan_map.svh"

module fcs_scan_top #(
  parameter int FLASH_WORDS = 16384,
  parameter int AW = $clog2(FLASH_WORDS)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Debugger write port and scan hold.
  input wire logic dbg_we_i,
  input wire logic [1:0] dbg_adr_i,
  input wire logic [7:0] dbg_dat_i,
  input wire logic dbg_hold_i,
  // Start-up scan request and section bounds.
  input wire logic startup_scan_i,
  input wire logic [1:0] startup_src_i,
  input wire logic [AW-1:0] boot_last_i,
  input wire logic [AW-1:0] app_last_i,
  // Flash read port.
  output logic flash_rd_o,
  output logic [AW-1:0] flash_addr_o,
  input wire logic [15:0] flash_data_i,
  // System signals.
  output logic nmi_o,
  output logic cpu_stall_o
);

  generate
    if (FLASH_WORDS < 2 || AW < 1 || (1 << AW) < FLASH_WORDS) begin : g_bad
      $error("fcs_scan_top: FLASH_WORDS or AW cannot be served");
    end
  endgenerate

  localparam logic [AW-1:0] FLASH_LAST = AW'(FLASH_WORDS - 1);

  // Folds one byte into the checksum, most significant bit first.
  function automatic logic [15:0] fcs_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ b[i]) ? ((c << 1) ^ `FCS_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : fcs_crc_byte

  fcs_scan_pkg::fcs_state_e state_reg, state_next;
  logic en_reg, en_next;
  logic failure_interrupt_enable_reg, failure_interrupt_enable_next;
  logic [1:0] mode_reg, mode_next;
  logic [1:0] src_reg, src_next;
  logic busy_reg, busy_next;
  logic pass_reg, pass_next;
  logic nmi_reg, nmi_next;
  logic srst_reg, srst_next;
  logic [1:0] dly_reg, dly_next;
  logic [1:0] div_reg, div_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [AW-1:0] last_reg, last_next;
  logic [15:0] crc_reg, crc_next;
  logic rd_reg, rd_next;
  logic [AW-1:0] faddr_reg, faddr_next;
  logic stall_reg, stall_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;

  fcs_scan_pkg::fcs_wr_s wr;
  logic bus_req, bus_wr, wr_first, wr_second, wr_state, srst_ok, start, fail_evt;
  logic [1:0] bus_idx;
  logic [1:0] start_src;
  logic [7:0] rd_byte;

  assign bus_idx = wb_adr_i[3:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  // Processor writes take the cycle; a debugger write in the same cycle is lost.
  always_comb begin
    wr = '0;
    if (bus_wr) begin
      wr.valid = 1'b1;
      wr.idx = bus_idx;
      wr.data = wb_dat_i[7:0];
    end else if (dbg_we_i) begin
      wr.valid = 1'b1;
      wr.from_dbg = 1'b1;
      wr.idx = dbg_adr_i;
      wr.data = dbg_dat_i;
    end
  end

  assign wr_first = wr.valid && wr.idx == `FCS_IDX_CTRL_FIRST && !nmi_reg;
  assign wr_second = wr.valid && wr.idx == `FCS_IDX_CTRL_SECOND && !nmi_reg && !busy_reg;
  assign wr_state = wr.valid && wr.from_dbg && wr.idx == `FCS_IDX_STATE && !nmi_reg;
  assign srst_ok = wr_first && wr.data[`FCS_BIT_SOFT_RESET] && (!failure_interrupt_enable_reg || !busy_reg);

  always_comb begin
    rd_byte = 8'h00;
    case (bus_idx)
      `FCS_IDX_CTRL_FIRST: begin
        rd_byte[`FCS_BIT_ENABLE] = en_reg;
        rd_byte[`FCS_BIT_FAIL_IRQ_EN] = failure_interrupt_enable_reg;
      end
      `FCS_IDX_CTRL_SECOND: begin
        rd_byte[`FCS_MODE_LSB +: 2] = mode_reg;
        rd_byte[`FCS_SRC_LSB +: 2] = src_reg;
      end
      `FCS_IDX_STATE: begin
        rd_byte[`FCS_BIT_BUSY] = busy_reg;
        rd_byte[`FCS_BIT_PASS] = pass_reg;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    en_next = en_reg;
    failure_interrupt_enable_next = failure_interrupt_enable_reg;
    mode_next = mode_reg;
    src_next = src_reg;
    busy_next = busy_reg;
    pass_next = pass_reg;
    nmi_next = nmi_reg;
    srst_next = srst_ok;
    dly_next = dly_reg;
    div_next = div_reg;
    addr_next = addr_reg;
    last_next = last_reg;
    crc_next = crc_reg;
    rd_next = 1'b0;
    faddr_next = faddr_reg;
    fail_evt = 1'b0;
    start = 1'b0;
    start_src = src_reg;
    ack_next = bus_req;
    rdat_next = {24'h000000, rd_byte};

    case (state_reg)
      fcs_scan_pkg::FCS_IDLE: begin
        busy_next = 1'b0;
      end
      fcs_scan_pkg::FCS_DELAY: begin
        if (dly_reg == `FCS_START_DLY_LAST) begin
          state_next = fcs_scan_pkg::FCS_RUN;
          addr_next = '0;
          div_next = `FCS_FETCH_ISSUE;
          crc_next = `FCS_CRC_INIT;
        end else begin
          dly_next = dly_reg + 2'h1;
        end
      end
      fcs_scan_pkg::FCS_RUN: begin
        if (!(div_reg == `FCS_FETCH_ISSUE && dbg_hold_i)) begin
          if (div_reg == `FCS_FETCH_ISSUE) begin
            rd_next = 1'b1;
            faddr_next = addr_reg;
          end
          if (div_reg == `FCS_FETCH_DIV_LAST) begin
            crc_next = fcs_crc_byte(fcs_crc_byte(crc_reg, flash_data_i[7:0]),
                                    flash_data_i[15:8]);
            div_next = `FCS_FETCH_ISSUE;
            if (addr_reg == last_reg) begin
              state_next = fcs_scan_pkg::FCS_CHECK;
            end else begin
              addr_next = addr_reg + AW'(1);
            end
          end else begin
            div_next = div_reg + 2'h1;
          end
        end
      end
      fcs_scan_pkg::FCS_CHECK: begin
        state_next = fcs_scan_pkg::FCS_IDLE;
        busy_next = 1'b0;
        pass_next = (crc_reg == `FCS_CRC_GOOD);
        fail_evt = (crc_reg != `FCS_CRC_GOOD) && failure_interrupt_enable_reg;
      end
      default: begin
        state_next = fcs_scan_pkg::FCS_IDLE;
        busy_next = 1'b0;
      end
    endcase

    if (wr_first) begin
      if (wr.data[`FCS_BIT_ENABLE] && !busy_reg) begin
        en_next = 1'b1;
        start = 1'b1;
      end
      if (wr.data[`FCS_BIT_FAIL_IRQ_EN] && !busy_reg) begin
        failure_interrupt_enable_next = 1'b1;
      end
    end
    if (wr_second) begin
      mode_next = wr.data[`FCS_MODE_LSB +: 2];
      src_next = wr.data[`FCS_SRC_LSB +: 2];
      start_src = wr.data[`FCS_SRC_LSB +: 2];
    end
    if (wr_state) begin
      if (!wr.data[`FCS_BIT_BUSY] && busy_reg) begin
        state_next = fcs_scan_pkg::FCS_IDLE;
        busy_next = 1'b0;
      end else if (wr.data[`FCS_BIT_BUSY] && !busy_reg) begin
        start = 1'b1;
      end
      if (wr.data[`FCS_BIT_PASS]) begin
        pass_next = 1'b1;
      end else begin
        pass_next = 1'b0;
        fail_evt = fail_evt || failure_interrupt_enable_reg;
      end
    end
    if (startup_scan_i && !busy_reg && !start) begin
      start = 1'b1;
      en_next = 1'b1;
      mode_next = `FCS_MODE_STARTUP;
      src_next = startup_src_i;
      start_src = startup_src_i;
    end
    if (start) begin
      state_next = fcs_scan_pkg::FCS_DELAY;
      busy_next = 1'b1;
      dly_next = 2'h0;
      case (start_src)
        `FCS_SRC_BOOT_AND_APP: last_next = app_last_i;
        `FCS_SRC_BOOT: last_next = boot_last_i;
        `FCS_SRC_FLASH: last_next = FLASH_LAST;
        default: last_next = boot_last_i;
      endcase
    end

    if (srst_reg) begin
      state_next = fcs_scan_pkg::FCS_IDLE;
      en_next = `FCS_RST_ENABLE;
      mode_next = `FCS_RST_MODE;
      src_next = `FCS_RST_SRC;
      busy_next = `FCS_RST_BUSY;
      pass_next = `FCS_CLR_PASS;
      rd_next = 1'b0;
      fail_evt = 1'b0;
    end
    nmi_next = nmi_reg || fail_evt;
  end

  assign stall_next = busy_next && mode_next == `FCS_MODE_PRIORITY;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= fcs_scan_pkg::FCS_IDLE;
      en_reg <= `FCS_RST_ENABLE;
      failure_interrupt_enable_reg <= `FCS_RST_FAIL_IRQ_EN;
      mode_reg <= `FCS_RST_MODE;
      src_reg <= `FCS_RST_SRC;
      busy_reg <= `FCS_RST_BUSY;
      pass_reg <= `FCS_RST_PASS;
      nmi_reg <= 1'b0;
      srst_reg <= 1'b0;
      dly_reg <= 2'h0;
      div_reg <= 2'h0;
      addr_reg <= '0;
      last_reg <= '0;
      crc_reg <= `FCS_CRC_INIT;
      rd_reg <= 1'b0;
      faddr_reg <= '0;
      stall_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      en_reg <= en_next;
      failure_interrupt_enable_reg <= failure_interrupt_enable_next;
      mode_reg <= mode_next;
      src_reg <= src_next;
      busy_reg <= busy_next;
      pass_reg <= pass_next;
      nmi_reg <= nmi_next;
      srst_reg <= srst_next;
      dly_reg <= dly_next;
      div_reg <= div_next;
      addr_reg <= addr_next;
      last_reg <= last_next;
      crc_reg <= crc_next;
      rd_reg <= rd_next;
      faddr_reg <= faddr_next;
      stall_reg <= stall_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign flash_rd_o = rd_reg;
  assign flash_addr_o = faddr_reg;
  assign nmi_o = nmi_reg;
  assign cpu_stall_o = stall_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_srst_taken;
    srst_ok;
  endsequence
  sequence s_regs_cleared;
    !en_reg && mode_reg == `FCS_RST_MODE && src_reg == `FCS_RST_SRC && !busy_reg;
  endsequence

  property p_srst_clear;
    s_srst_taken ##1 srst_reg |=> s_regs_cleared;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset did not clear");

  property p_failure_interrupt_enable_kept;
    (srst_reg && failure_interrupt_enable_reg) |=> failure_interrupt_enable_reg;
  endproperty
  a_failure_interrupt_enable_kept: assert property (p_failure_interrupt_enable_kept) else $error("soft reset cleared enable");

  property p_nmi_sticky;
    nmi_o |=> nmi_o;
  endproperty
  a_nmi_sticky: assert property (p_nmi_sticky) else $error("interrupt request dropped");

  property p_fail_nmi;
    (state_reg == fcs_scan_pkg::FCS_CHECK && crc_reg != `FCS_CRC_GOOD && failure_interrupt_enable_reg
     && !srst_reg && !wr_state) |=> nmi_o && !pass_reg;
  endproperty
  a_fail_nmi: assert property (p_fail_nmi) else $error("mismatch without interrupt");

  property p_check_result;
    (state_reg == fcs_scan_pkg::FCS_CHECK && !srst_reg && !wr_state)
      |=> !busy_reg && pass_reg == ($past(crc_reg) == `FCS_CRC_GOOD);
  endproperty
  a_check_result: assert property (p_check_result) else $error("wrong pass result");

  property p_delay_exit;
    ($rose(busy_reg) && !srst_reg && !wr_state) ##1 (!srst_reg && !wr_state) [*2]
      |=> state_reg == fcs_scan_pkg::FCS_RUN && $past(state_reg) == fcs_scan_pkg::FCS_DELAY;
  endproperty
  a_delay_exit: assert property (p_delay_exit) else $error("check began early or late");

  property p_fetch_spacing;
    flash_rd_o |=> !flash_rd_o [*2];
  endproperty
  a_fetch_spacing: assert property (p_fetch_spacing) else $error("fetch spacing too short");

  property p_second_locked;
    ((busy_reg || nmi_o) && !srst_reg && !startup_scan_i) |=> $stable({mode_reg, src_reg});
  endproperty
  a_second_locked: assert property (p_second_locked) else $error("locked register changed");

  property p_failure_interrupt_enable_idle;
    $rose(failure_interrupt_enable_reg) |-> !$past(busy_reg);
  endproperty
  a_failure_interrupt_enable_idle: assert property (p_failure_interrupt_enable_idle) else $error("enable set while busy");

  property p_dbg_clear_nmi;
    (wr_state && !wr.data[`FCS_BIT_PASS] && failure_interrupt_enable_reg && !srst_reg) |=> nmi_o ##1 nmi_o;
  endproperty
  a_dbg_clear_nmi: assert property (p_dbg_clear_nmi) else $error("debug clear no interrupt");

  property p_stall_priority;
    (busy_reg && mode_reg == `FCS_MODE_PRIORITY) |-> cpu_stall_o;
  endproperty
  a_stall_priority: assert property (p_stall_priority) else $error("processor not stalled");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

endmodule : fcs_scan_top

// File: verification/fcs_flash_model.sv
/*
  Flash array model for the scanner's read port. Assumes one word is
  returned the cycle after a read pulse and that the bench loads mem.
*/
`timescale 1ns/1ps

module fcs_flash_model #(
  parameter int AW = 4
) (
  // Clock.
  input wire logic clk_i,
  // Read port.
  input wire logic rd_i,
  input wire logic [AW-1:0] addr_i,
  output logic [15:0] data_o
);
  logic [15:0] mem [2**AW];

  // Outside a read the bus toggles every cycle so stale data never matches.
  initial data_o = 16'h0000;
  always @(posedge clk_i) begin
    data_o <= rd_i ? mem[addr_i] : ~data_o;
  end
endmodule : fcs_flash_model

// File: verification/flash_crc_scan_control_test.sv
/*
  Self-checking bench of the flash checksum scanner: Wishbone and
  debugger register traffic, section scans, soft reset and failure interrupt.
  Assumes a 16-word flash model behind the read port.
*/
`timescale 1ns/1ps

module flash_crc_scan_control_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, wb_dat_o;
  logic wb_ack_o, dbg_we = 1'b0, st_scan = 1'b0;
  logic [3:0] sel = 4'h0, sel_mask = 4'hF;
  logic [1:0] st_src = 2'h1;
  logic [1:0] dbg_adr = 2'h0;
  logic [7:0] dbg_dat = 8'h00, d;
  logic flash_rd_o, nmi_o, cpu_stall_o;
  logic [3:0] flash_addr_o;
  logic [15:0] fdat, crc;
  int errors = 0, check_count = 0, rd_cnt = 0, tick = 0, last_tick = 0;
  realtime t_ack, t_rd;

  initial forever #2.5 clk_i = ~clk_i;

  fcs_scan_top #(.FLASH_WORDS(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dbg_we_i(dbg_we), .dbg_adr_i(dbg_adr),
    .dbg_dat_i(dbg_dat), .dbg_hold_i(1'b0), .startup_scan_i(st_scan),
    .startup_src_i(st_src), .boot_last_i(4'h3), .app_last_i(4'h7),
    .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o), .flash_data_i(fdat),
    .nmi_o(nmi_o), .cpu_stall_o(cpu_stall_o));

  fcs_flash_model #(.AW(4)) u_flash (.clk_i(clk_i), .rd_i(flash_rd_o),
    .addr_i(flash_addr_o), .data_o(fdat));

  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Read pulses within a scan are three cycles apart; a gap of more than eight cycles opens a new scan.
  always @(posedge clk_i) begin
    tick++;
    if (tick == 20000) begin
      errors++;
      results();
    end
    if (flash_rd_o === 1'b1) begin
      if (rd_cnt == 0 || tick - last_tick > 8) begin
        rd_cnt = 0;
        t_rd = $realtime;
      end else begin
        check(tick - last_tick, 3);
      end
      rd_cnt++;
      last_tick = tick;
    end
  end

  task automatic wb_io(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_mask;
    adr <= a;
    wdat <= {24'h0, v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o[7:0];
    t_ack = $realtime;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_io

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    wb_io(1'b0, a, 8'h00);
    check(d, exp);
  endtask : rd

  task automatic dbg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    dbg_we <= 1'b1;
    dbg_adr <= a;
    dbg_dat <= v;
    @(posedge clk_i);
    dbg_we <= 1'b0;
  endtask : dbg

  task automatic wait_idle(input logic [7:0] exp);
    do wb_io(1'b0, 4'h8, 8'h00); while (d[0] !== 1'b0);
    check(d, exp);
  endtask : wait_idle

  task automatic scan(input logic [1:0] sec, input int words);
    realtime t_go;
    wb_io(1'b1, 4'h4, {6'h0, sec});
    rd_cnt = 0;
    wb_io(1'b1, 4'h0, 8'h01);
    t_go = t_ack;
    rd(4'h8, 8'h03);
    check(cpu_stall_o, 1'b1);
    wait_idle(8'h02);
    check(rd_cnt, words);
    // From the ack edge: three delay cycles, then the cycle that issues the first fetch.
    check(int'((t_rd - t_go) / 5.0), 4);
    rd(4'h0, 8'h01);
  endtask : scan

  initial begin
    // Valid checksums close the boot, boot+app and whole-flash sections.
    crc = 16'hFFFF;
    for (int i = 0; i < 16; i++) begin
      if (i == 3 || i == 7 || i == 15) u_flash.mem[i] = {crc[7:0], crc[15:8]};
      else u_flash.mem[i] = 16'h1357 + 16'h0F1D * i[15:0];
      for (int b = 0; b < 16; b++) begin
        logic fb;
        fb = crc[15] ^ u_flash.mem[i][(b < 8) ? 7 - b : 23 - b];
        crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h02);
    rd(4'hC, 8'h00);
    wb_io(1'b1, 4'h4, 8'hFF);
    rd(4'h4, 8'h33);
    sel_mask = 4'hE;
    wb_io(1'b1, 4'h4, 8'h00);
    sel_mask = 4'hF;
    rd(4'h4, 8'h33);
    scan(2'h0, 16);
    scan(2'h1, 8);
    scan(2'h2, 4);
    scan(2'h3, 4);
    wb_io(1'b1, 4'h4, 8'h02);
    wb_io(1'b1, 4'h0, 8'h01);
    wb_io(1'b1, 4'h4, 8'h01);
    wb_io(1'b1, 4'h0, 8'h03);
    wb_io(1'b1, 4'h0, 8'h00);
    wait_idle(8'h02);
    rd(4'h4, 8'h02);
    rd(4'h0, 8'h01);
    wb_io(1'b1, 4'h0, 8'h01);
    wb_io(1'b1, 4'h0, 8'h80);
    rd(4'h8, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    dbg(2'h2, 8'h02);
    rd(4'h8, 8'h02);
    dbg(2'h1, 8'h02);
    rd(4'h4, 8'h02);
    dbg(2'h0, 8'h01);
    rd(4'h8, 8'h03);
    wait_idle(8'h02);
    @(posedge clk_i);
    st_scan <= 1'b1;
    @(posedge clk_i);
    st_scan <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(cpu_stall_o, 1'b0);
    wait_idle(8'h02);
    rd(4'h0, 8'h01);
    rd(4'h4, 8'h11);
    wb_io(1'b1, 4'h4, 8'h02);
    wb_io(1'b1, 4'h0, 8'h02);
    rd(4'h0, 8'h03);
    wb_io(1'b1, 4'h0, 8'h80);
    rd(4'h0, 8'h02);
    wb_io(1'b1, 4'h4, 8'h02);
    wb_io(1'b1, 4'h0, 8'h01);
    wb_io(1'b1, 4'h0, 8'h80);
    rd(4'h8, 8'h01);
    wait_idle(8'h02);
    u_flash.mem[1] = u_flash.mem[1] ^ 16'h0100;
    wb_io(1'b1, 4'h0, 8'h01);
    wait_idle(8'h00);
    check(nmi_o, 1'b1);
    wb_io(1'b1, 4'h0, 8'h80);
    rd(4'h0, 8'h03);
    wb_io(1'b1, 4'h4, 8'h01);
    rd(4'h4, 8'h02);
    check(nmi_o, 1'b1);
    u_flash.mem[1] = u_flash.mem[1] ^ 16'h0100;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(nmi_o, 1'b0);
    wb_io(1'b1, 4'h0, 8'h02);
    dbg(2'h2, 8'h00);
    repeat (3) @(posedge clk_i);
    check(nmi_o, 1'b1);
    dbg(2'h1, 8'h01);
    rd(4'h4, 8'h00);
    results();
  end
endmodule : flash_crc_scan_control_test
